// file: jtp_defs.svh
// constants for the configuration programming test port
// assumes a single 50 MHz core clock; test pins are sampled, not used as clocks
`ifndef JTP_DEFS_SVH
`define JTP_DEFS_SVH

// ------------------------------------------------------------
// instruction codes
// ------------------------------------------------------------
`define JTP_IR_W 8
`define JTP_I_EXTEST 8'h00
`define JTP_I_BULK_ERASE 8'h03
`define JTP_I_PROG_FUSE 8'h09
`define JTP_I_DISCHARGE 8'h14
`define JTP_I_PROG_EN 8'h15
`define JTP_I_IDREAD 8'h16
`define JTP_I_SIG_READ 8'h17
`define JTP_I_SIG_PROG 8'h1a
`define JTP_I_SAMPLE 8'h1c
`define JTP_I_PROG_DIS 8'h1e
`define JTP_I_RESET 8'h22
`define JTP_I_ERASE_DONE 8'h24
`define JTP_I_CFG_VERIFY 8'h28
`define JTP_I_CFG_ERASE 8'h29
`define JTP_I_CFG_ADDR 8'h2b
`define JTP_I_CFG_DATA 8'h2d
`define JTP_I_CFG_PROG 8'h2e
`define JTP_I_PROG_DONE 8'h2f
`define JTP_I_BYPASS 8'hff

// ------------------------------------------------------------
// register sizes and reset values
// ------------------------------------------------------------
`define JTP_ADDR_W 4
`define JTP_DATA_W 56
`define JTP_SIG_W 32
`define JTP_CFG_ROWS 16
`define JTP_SIG_RST 32'hffffffff
`define JTP_CFG_RST 56'hffffffffffffff
`define JTP_IR_CAPTURE 8'h01

`endif

// file: jtp_pkg.sv
// types for the configuration programming test port
// assumes jtp_defs.svh is on the include path
`include "jtp_defs.svh"
package jtp_pkg;
  typedef enum logic [3:0] {
    JTP_RESET, JTP_IDLE, JTP_SEL_DR, JTP_CAP_DR, JTP_SHIFT_DR, JTP_EXIT1_DR, JTP_PAUSE_DR,
    JTP_EXIT2_DR, JTP_UPD_DR, JTP_SEL_IR, JTP_CAP_IR, JTP_SHIFT_IR, JTP_EXIT1_IR,
    JTP_PAUSE_IR, JTP_EXIT2_IR, JTP_UPD_IR
  } jtp_tap_type;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] tck_sync0;
    logic [1:0] tck_sync1;
    logic tms_s0;
    logic tms_s1;
    logic tdi_s0;
    logic tdi_s1;
    logic tck_prev;
    jtp_tap_type tap;
    logic [`JTP_IR_W-1:0] ir_shift;
    logic [`JTP_IR_W-1:0] ir;
    logic [`JTP_DATA_W-1:0] dr;
    logic [`JTP_ADDR_W-1:0] cfg_addr;
    logic [`JTP_DATA_W-1:0] cfg_latch;
    logic [`JTP_SIG_W-1:0] sig_latch;
    logic [`JTP_SIG_W-1:0] user_signature_word;
    logic [`JTP_CFG_ROWS*`JTP_DATA_W-1:0] cfg_mem;
    logic readout_security_fuse;
    logic prog_mode;
    logic done_bit;
    logic op_armed;
    logic [1:0] idle_edges;
    logic tdo;
    logic tdo_en;
    logic verify_fail;
    logic dev_reset;
  } jtp_state_type;
endpackage

// file: jtp_prog_model.sv
// model of the external programmer driving the test pins
// assumes it is called at a falling core clock edge; the test clock rests low between frames
module jtp_prog_model (
  input wire logic clk_in,
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // one 160 ns period: inputs set low, output sampled at the rise
  task automatic step(input logic ms, input logic di, output logic dout);
    tms_out = ms;
    tdi_out = di;
    repeat (4) @(negedge clk_in);
    dout = tdo_in;
    tck_out = 1'b1;
    repeat (4) @(negedge clk_in);
    tck_out = 1'b0;
  endtask
  // don't-care data is inverted so a stale value never looks valid
  task automatic hold(input logic ms, input int k);
    logic d;
    repeat (k) step(ms, ~tdi_out, d);
  endtask
  // full scan from idle back to idle, optional pause after bit pa
  task automatic scan(input bit ir, input int n, input logic [55:0] din, input int pa,
    output logic [55:0] dout);
    logic d;
    dout = 56'h0;
    step(1'b1, ~tdi_out, d);
    if (ir) step(1'b1, ~tdi_out, d);
    step(1'b0, ~tdi_out, d);
    step(1'b0, ~tdi_out, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pa, din[i], d);
      dout[i] = d;
      if (i == pa) for (int k = 0; k < 4; k++) step(k == 2, ~tdi_out, d);
    end
    step(1'b1, ~tdi_out, d);
    step(1'b0, ~tdi_out, d);
  endtask
endmodule

// file: jtp_tap_programmer.sv
// test access port that programs the non-volatile configuration store
// assumes test pins are asynchronous to CORE_CLK_IN and the test clock runs well below it
`include "jtp_defs.svh"
module jtp_tap_programmer
  import jtp_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h0a5c0001 // arbitrary identification value
) (
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic TCK_IN,
  input wire logic TMS_IN,
  input wire logic TDI_IN,
  output logic TDO_OUT,
  output logic TDO_EN_OUT,
  output logic PROG_MODE_OUT,
  output logic SECURE_OUT,
  output logic VERIFY_FAIL_OUT,
  output logic DEV_RESET_OUT
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // standard test port next-state table
  function automatic jtp_tap_type tap_next(input jtp_tap_type s, input logic m);
    unique case (s)
      JTP_RESET: tap_next = m ? JTP_RESET : JTP_IDLE;
      JTP_IDLE: tap_next = m ? JTP_SEL_DR : JTP_IDLE;
      JTP_SEL_DR: tap_next = m ? JTP_SEL_IR : JTP_CAP_DR;
      JTP_CAP_DR: tap_next = m ? JTP_EXIT1_DR : JTP_SHIFT_DR;
      JTP_SHIFT_DR: tap_next = m ? JTP_EXIT1_DR : JTP_SHIFT_DR;
      JTP_EXIT1_DR: tap_next = m ? JTP_UPD_DR : JTP_PAUSE_DR;
      JTP_PAUSE_DR: tap_next = m ? JTP_EXIT2_DR : JTP_PAUSE_DR;
      JTP_EXIT2_DR: tap_next = m ? JTP_UPD_DR : JTP_SHIFT_DR;
      JTP_UPD_DR: tap_next = m ? JTP_SEL_DR : JTP_IDLE;
      JTP_SEL_IR: tap_next = m ? JTP_RESET : JTP_CAP_IR;
      JTP_CAP_IR: tap_next = m ? JTP_EXIT1_IR : JTP_SHIFT_IR;
      JTP_SHIFT_IR: tap_next = m ? JTP_EXIT1_IR : JTP_SHIFT_IR;
      JTP_EXIT1_IR: tap_next = m ? JTP_UPD_IR : JTP_PAUSE_IR;
      JTP_PAUSE_IR: tap_next = m ? JTP_EXIT2_IR : JTP_PAUSE_IR;
      JTP_EXIT2_IR: tap_next = m ? JTP_UPD_IR : JTP_SHIFT_IR;
      JTP_UPD_IR: tap_next = m ? JTP_SEL_DR : JTP_IDLE;
    endcase
  endfunction

  // length of the data path that the instruction selects
  function automatic int unsigned dr_len(input logic [`JTP_IR_W-1:0] i);
    unique case (i)
      `JTP_I_IDREAD, `JTP_I_SIG_READ: dr_len = `JTP_SIG_W;
      `JTP_I_CFG_ADDR: dr_len = `JTP_ADDR_W;
      `JTP_I_CFG_DATA: dr_len = `JTP_DATA_W;
      default: dr_len = 1; // bypass, sample, external test and all others
    endcase
  endfunction

  // long operations that wait for idle entry
  function automatic logic is_idle_op(input logic [`JTP_IR_W-1:0] i);
    is_idle_op = (i == `JTP_I_BULK_ERASE) || (i == `JTP_I_PROG_FUSE) || (i == `JTP_I_SIG_PROG)
      || (i == `JTP_I_CFG_VERIFY) || (i == `JTP_I_CFG_ERASE) || (i == `JTP_I_CFG_PROG)
      || (i == `JTP_I_ERASE_DONE) || (i == `JTP_I_PROG_DONE);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  jtp_state_type st;
  jtp_state_type next_st;
  logic rst_n;
  logic tck_rise;
  logic tck_fall;
  int unsigned len;

  assign rst_n = st.rst_sync[1];
  assign tck_rise = st.tck_sync1[0] & ~st.tck_prev;
  assign tck_fall = ~st.tck_sync1[0] & st.tck_prev;
  assign len = dr_len(st.ir);

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------

  // all behaviour except the synchronisers and the reset pulse clear advances only on detected test clock edges
  always_comb begin
    logic [`JTP_DATA_W-1:0] row;
    logic [`JTP_DATA_W-1:0] cap;
    logic [`JTP_DATA_W-1:0] shifted;
    next_st = st;
    row = st.cfg_mem[st.cfg_addr*`JTP_DATA_W +: `JTP_DATA_W];
    cap = '0;
    shifted = st.dr;
    next_st.rst_sync = {st.rst_sync[0], 1'b1};
    // two-stage synchronisers; only the second stage is read
    next_st.tck_sync0 = {1'b0, TCK_IN};
    next_st.tck_sync1 = {1'b0, st.tck_sync0[0]};
    next_st.tms_s0 = TMS_IN;
    next_st.tms_s1 = st.tms_s0;
    next_st.tdi_s0 = TDI_IN;
    next_st.tdi_s1 = st.tdi_s0;
    next_st.tck_prev = st.tck_sync1[0];
    next_st.dev_reset = 1'b0;
    if (tck_rise) begin
      next_st.tap = tap_next(st.tap, st.tms_s1);
      unique case (st.tap)
        JTP_RESET: begin
          next_st.ir = `JTP_I_IDREAD; // identification selected after reset
          next_st.prog_mode = 1'b0; // reset state cancels program mode
          next_st.op_armed = 1'b0;
        end
        JTP_IDLE: begin
          // operation fires on the second rising edge in idle
          if (st.op_armed && st.idle_edges == 2'h1) begin
            next_st.op_armed = 1'b0;
            unique case (st.ir)
              `JTP_I_BULK_ERASE: begin
                next_st.cfg_mem = {`JTP_CFG_ROWS{`JTP_CFG_RST}};
                next_st.user_signature_word = `JTP_SIG_RST;
                next_st.readout_security_fuse = 1'b0;
                next_st.done_bit = 1'b0;
              end
              `JTP_I_CFG_ERASE: next_st.cfg_mem = {`JTP_CFG_ROWS{`JTP_CFG_RST}};
              `JTP_I_PROG_FUSE: next_st.readout_security_fuse = 1'b1;
              `JTP_I_SIG_PROG: next_st.user_signature_word = st.sig_latch;
              `JTP_I_CFG_PROG: next_st.cfg_mem[st.cfg_addr*`JTP_DATA_W +: `JTP_DATA_W] = row & st.cfg_latch;
              `JTP_I_CFG_VERIFY: next_st.verify_fail = st.readout_security_fuse || (row != st.cfg_latch);
              `JTP_I_ERASE_DONE: next_st.done_bit = 1'b0;
              `JTP_I_PROG_DONE: next_st.done_bit = 1'b1;
              default: ;
            endcase
          end
          if (st.idle_edges != 2'h3) begin
            next_st.idle_edges = st.idle_edges + 2'h1;
          end
        end
        JTP_CAP_DR: begin
          // parallel load of the selected path
          unique case (st.ir)
            `JTP_I_IDREAD: cap[`JTP_SIG_W-1:0] = ID_VALUE;
            `JTP_I_SIG_READ: cap[`JTP_SIG_W-1:0] = st.user_signature_word;
            `JTP_I_CFG_ADDR: cap[`JTP_ADDR_W-1:0] = st.cfg_addr;
            `JTP_I_CFG_DATA: cap = st.readout_security_fuse ? '0 : row;
            default: cap = '0; // one-bit bypass captures zero
          endcase
          next_st.dr = cap;
        end
        JTP_SHIFT_DR: begin
          // shift toward bit 0, new bit enters at the path's top
          shifted = st.dr >> 1;
          shifted[len-1] = st.tdi_s1;
          next_st.dr = shifted;
        end
        JTP_UPD_DR: begin
          unique case (st.ir)
            `JTP_I_CFG_ADDR: next_st.cfg_addr = st.dr[`JTP_ADDR_W-1:0];
            `JTP_I_CFG_DATA: next_st.cfg_latch = st.dr;
            `JTP_I_SIG_READ: next_st.sig_latch = st.dr[`JTP_SIG_W-1:0];
            default: ;
          endcase
        end
        JTP_CAP_IR: next_st.ir_shift = `JTP_IR_CAPTURE;
        JTP_SHIFT_IR: next_st.ir_shift = {st.tdi_s1, st.ir_shift[`JTP_IR_W-1:1]};
        JTP_UPD_IR: begin
          next_st.ir = st.ir_shift;
          next_st.op_armed = is_idle_op(st.ir_shift);
          // short instructions take effect here
          unique case (st.ir_shift)
            `JTP_I_PROG_EN: next_st.prog_mode = 1'b1;
            `JTP_I_PROG_DIS: next_st.prog_mode = 1'b0;
            `JTP_I_RESET: next_st.dev_reset = 1'b1;
            default: ;
          endcase
          // non-volatile actions except verify need program mode
          if (!st.prog_mode && st.ir_shift != `JTP_I_CFG_VERIFY) begin
            next_st.op_armed = 1'b0;
          end
        end
        default: ;
      endcase
      // capture-ir loads the identification instruction
      if (st.tap == JTP_CAP_IR) begin
        next_st.ir = `JTP_I_IDREAD;
      end
      if (st.tap != JTP_IDLE) begin
        next_st.idle_edges = 2'h0;
      end
    end
    // output changes on the falling edge
    if (tck_fall) begin
      next_st.tdo_en = (st.tap == JTP_SHIFT_DR) || (st.tap == JTP_SHIFT_IR);
      next_st.tdo = (st.tap == JTP_SHIFT_IR) ? st.ir_shift[0] : st.dr[0];
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------

  // the raw reset zeroes most registers and presets the store, signature, latches and instruction; while its synchronised copy is low only the synchroniser advances
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st <= '0;
      st.tap <= JTP_RESET;
      st.ir <= `JTP_I_IDREAD;
      st.user_signature_word <= `JTP_SIG_RST;
      st.cfg_mem <= {`JTP_CFG_ROWS{`JTP_CFG_RST}};
      st.cfg_latch <= `JTP_CFG_RST;
      st.sig_latch <= `JTP_SIG_RST;
    end else if (!rst_n) begin
      st.rst_sync <= next_st.rst_sync;
    end else begin
      st <= next_st;
    end
  end

  assign TDO_OUT = st.tdo;
  assign TDO_EN_OUT = st.tdo_en;
  assign PROG_MODE_OUT = st.prog_mode;
  assign SECURE_OUT = st.readout_security_fuse;
  assign VERIFY_FAIL_OUT = st.verify_fail;
  assign DEV_RESET_OUT = st.dev_reset;

endmodule

// file: jtp_tap_programmer_assertions.sv
// pin-level checker for the configuration test port
// assumes each test clock phase lasts at least four core cycles
module jtp_tap_checker (
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic TCK_IN,
  input wire logic TMS_IN,
  input wire logic TDI_IN,
  input wire logic TDO_OUT,
  input wire logic TDO_EN_OUT,
  input wire logic PROG_MODE_OUT,
  input wire logic SECURE_OUT,
  input wire logic VERIFY_FAIL_OUT,
  input wire logic DEV_RESET_OUT
);
  logic tck_q;
  logic [2:0] hi_cnt;
  // test clock rises with mode-select high, saturating so it never wraps
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tck_q <= 1'b0;
      hi_cnt <= 3'h0;
    end else begin
      tck_q <= TCK_IN;
      if (TCK_IN && !tck_q) hi_cnt <= !TMS_IN ? 3'h0 : (hi_cnt == 3'h7 ? hi_cnt : hi_cnt + 3'h1);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // outputs lag the pin by up to three cycles, hence the look one cycle back
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  property p_tdo_fall; $changed(TDO_OUT) |-> !$past(TCK_IN); endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a fall");
  property p_en_fall; $changed(TDO_EN_OUT) |-> !$past(TCK_IN); endproperty
  a_en_fall: assert property (p_en_fall) else $error("enable moved off a fall");
  property p_tlr_five; hi_cnt >= 3'h5 |-> !TDO_EN_OUT; endproperty
  a_tlr_five: assert property (p_tlr_five) else $error("no reset after five");
  property p_rst_pulse; $rose(DEV_RESET_OUT) |=> !DEV_RESET_OUT; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  property p_rst_upd; DEV_RESET_OUT |-> $past(TCK_IN); endproperty
  a_rst_upd: assert property (p_rst_upd) else $error("reset off a rise");
  property p_prog_rise; $changed(PROG_MODE_OUT) |-> $past(TCK_IN); endproperty
  a_prog_rise: assert property (p_prog_rise) else $error("mode off a rise");
  property p_fuse_set; $rose(SECURE_OUT) |-> PROG_MODE_OUT; endproperty
  a_fuse_set: assert property (p_fuse_set) else $error("fuse set unprotected");
  property p_fuse_clr; $fell(SECURE_OUT) |-> PROG_MODE_OUT && $past(TCK_IN); endproperty
  a_fuse_clr: assert property (p_fuse_clr) else $error("fuse cleared oddly");
  property p_vfy_rise; $changed(VERIFY_FAIL_OUT) |-> $past(TCK_IN); endproperty
  a_vfy_rise: assert property (p_vfy_rise) else $error("verify off a rise");
endmodule
bind jtp_tap_programmer jtp_tap_checker u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RSTN_IN(RSTN_IN),
  .TCK_IN(TCK_IN), .TMS_IN(TMS_IN), .TDI_IN(TDI_IN), .TDO_OUT(TDO_OUT), .TDO_EN_OUT(TDO_EN_OUT),
  .PROG_MODE_OUT(PROG_MODE_OUT), .SECURE_OUT(SECURE_OUT), .VERIFY_FAIL_OUT(VERIFY_FAIL_OUT),
  .DEV_RESET_OUT(DEV_RESET_OUT));

// file: jtp_tap_programmer_bench.sv
// self-checking bench for the configuration test port
// assumes the checker bind and the programmer model are compiled first
`include "jtp_defs.svh"
module jtp_tap_programmer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ID = 32'h3c690002; // arbitrary identification value
  logic clk, rstn, tck, tms, tdi, tdo, tdo_en, prog_mode, secure, vfail, dev_rst;
  logic [55:0] got;
  int num_errors = 0;
  int comparisons = 0;
  int rst_pulses = 0;
  jtp_tap_programmer #(.ID_VALUE(ID)) u_dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .TCK_IN(tck),
    .TMS_IN(tms), .TDI_IN(tdi), .TDO_OUT(tdo), .TDO_EN_OUT(tdo_en), .PROG_MODE_OUT(prog_mode),
    .SECURE_OUT(secure), .VERIFY_FAIL_OUT(vfail), .DEV_RESET_OUT(dev_rst));
  jtp_prog_model u_prog (.clk_in(clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dev_rst === 1'b1) rst_pulses++;
  end
  task automatic chk(input string nm, input logic [55:0] seen, input logic [55:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ir(input logic [7:0] code);
    u_prog.scan(1'b1, 8, {48'h0, code}, -1, got);
  endtask
  task automatic dr(input int n, input logic [55:0] din, input int pa);
    u_prog.scan(1'b0, n, din, pa, got);
  endtask
  task automatic t_id();
    u_prog.hold(1'b0, 1);
    dr(32, 56'h0, -1);
    chk("idcode", got[31:0], ID);
    ir(`JTP_I_IDREAD);
    chk("ir capture", got[7:0], `JTP_IR_CAPTURE);
    dr(32, 56'h0, 9);
    chk("paused id", got[31:0], ID);
  endtask
  task automatic t_byp();
    logic [7:0] codes [3] = '{`JTP_I_BYPASS, `JTP_I_EXTEST, `JTP_I_SAMPLE};
    foreach (codes[i]) begin
      ir(codes[i]);
      dr(8, 56'h5a, -1);
      chk("bypass", got[7:0], 8'hb4);
    end
  endtask
  task automatic t_sig();
    ir(`JTP_I_PROG_EN);
    chk("prog on", prog_mode, 1'b1);
    ir(`JTP_I_SIG_READ);
    dr(32, 56'h5ac3e7d1, -1);
    chk("sig reset", got[31:0], `JTP_SIG_RST);
    ir(`JTP_I_SIG_PROG);
    u_prog.hold(1'b0, 1);
    ir(`JTP_I_PROG_DIS);
    chk("prog off", prog_mode, 1'b0);
    ir(`JTP_I_SIG_READ);
    dr(32, 56'h0, -1);
    chk("sig", got[31:0], 32'h5ac3e7d1);
  endtask
  // address, data, then program; verify both ways, then lock and erase
  task automatic t_cfg();
    ir(`JTP_I_PROG_EN);
    ir(`JTP_I_CFG_ADDR);
    dr(4, 56'h5, -1);
    ir(`JTP_I_CFG_DATA);
    dr(56, 56'h0123456789abcd, -1);
    ir(`JTP_I_CFG_PROG);
    u_prog.hold(1'b0, 1);
    ir(`JTP_I_CFG_VERIFY);
    u_prog.hold(1'b0, 2);
    chk("verify ok", vfail, 1'b0);
    ir(`JTP_I_CFG_DATA);
    dr(56, 56'hfedcba98765432, -1);
    ir(`JTP_I_CFG_VERIFY);
    chk("verify wait", vfail, 1'b0);
    u_prog.hold(1'b0, 2);
    chk("verify bad", vfail, 1'b1);
    ir(`JTP_I_PROG_FUSE);
    u_prog.hold(1'b0, 2);
    chk("fuse", secure, 1'b1);
    ir(`JTP_I_CFG_DATA);
    dr(56, 56'h0, -1);
    chk("locked", got, 56'h0);
    ir(`JTP_I_BULK_ERASE);
    u_prog.hold(1'b0, 2);
    chk("erased", secure, 1'b0);
  endtask
  task automatic t_rst();
    ir(`JTP_I_RESET);
    chk("dev reset", rst_pulses, 1);
    ir(`JTP_I_BYPASS);
    u_prog.hold(1'b1, 1);
    u_prog.hold(1'b0, 2);
    repeat (5) @(negedge clk);
    chk("shift en", tdo_en, 1'b1);
    u_prog.hold(1'b1, 5);
    chk("tlr en", tdo_en, 1'b0);
    u_prog.hold(1'b0, 1);
    dr(32, 56'h0, -1);
    chk("id after tlr", got[31:0], ID);
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    t_id();
    t_byp();
    t_sig();
    t_cfg();
    t_rst();
    end_sim();
  end
  // roughly 730 test clock periods are needed; allow well over that
  initial begin
    #1000000;
    num_errors++;
    end_sim();
  end
endmodule
